// file: hw/spc_stack_ctrl.sv
// stack pointer and push/pop sequencer
`include "spc_params.svh"
`default_nettype none
module spc_stack_ctrl
(
    input  wire logic              clk_in,
    input  wire logic              rstn_in,
    input  wire spc_pkg::spc_op_e  op_in,
    input  wire spc_pkg::spc_frame_s frame_in,
    input  wire spc_pkg::spc_reg_s reg_in,
    input  wire logic [3:0]        mem_rdata_in,
    input  wire logic [1:0]        reg_bank_select_in,
    output logic [3:0]             reg_rdata_out,
    output spc_pkg::spc_mem_s      mem_out,
    output spc_pkg::spc_frame_s    frame_out,
    output logic                   done_out,
    output logic                   busy_out,
    output logic [7:0]             stack_top_pointer_out,
    output logic [1:0]             work_bank_out
);
    import spc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0]  stack_top_pointer_r;
    logic [7:0]  sp_nxt;
    spc_state_e  state_r;
    spc_op_e     op_r;
    logic [2:0]  cnt_r;
    logic [2:0]  total_r;
    logic [23:0] shift_r;
    logic [3:0]  reg_rdata_r;
    spc_mem_s    mem_r;
    spc_frame_s  frame_r;
    logic        done_r;
    logic [1:0]  work_bank_r;
    logic [7:0]  step_r;
    // read pipeline: ram answers one edge after it sees the strobe
    logic        rd_pend_r;
    logic        rd_last0_r;
    logic        rd_last_r;

    ////////////////////////////////////////////////////////////////////////
    // decode
    logic        hit_lo;
    logic        hit_hi;
    logic        idle;
    logic        sp_wr_lo;
    logic        sp_wr_hi;
    logic        is_push;
    logic        is_pop;
    logic        pair_op;
    logic [2:0]  nib_total;
    logic [7:0]  step;
    logic        last;
    logic        rd_strobe;
    logic        sp_busy_nxt;

    assign hit_lo    = reg_in.en && reg_in.addr == `SPC_ADDR_SP_LO;
    assign hit_hi    = reg_in.en && reg_in.addr == `SPC_ADDR_SP_HI;
    assign idle      = state_r == SPC_ST_IDLE;
    // writes land only while idle; a running sequence owns the pointer
    assign sp_wr_lo  = idle && reg_in.we && hit_lo;
    assign sp_wr_hi  = idle && reg_in.we && hit_hi;
    assign is_push   = op_in == SPC_OP_PUSH
                       || op_in == SPC_OP_CALL
                       || op_in == SPC_OP_INT;
    assign is_pop    = op_in == SPC_OP_POP
                       || op_in == SPC_OP_RET
                       || op_in == SPC_OP_INTERRUPT_EXIT_OP;
    assign pair_op   = op_in == SPC_OP_PUSH || op_in == SPC_OP_POP;
    assign nib_total = pair_op ? `SPC_NIB_PAIR : `SPC_NIB_FRAME;
    assign step      = pair_op ? `SPC_STEP_PAIR : `SPC_STEP_FRAME;
    assign last      = cnt_r == total_r - 3'h1;
    assign rd_strobe = mem_r.en && !mem_r.we;
    // busy also covers the read tail, when the state is already idle
    assign sp_busy_nxt = !(idle && op_in == SPC_OP_NONE)
                         || rd_strobe
                         || rd_pend_r;

    ////////////////////////////////////////////////////////////////////////
    // frame data
    logic [7:0]  psw_cat;
    logic [7:0]  flag_cat;
    logic [23:0] push_data;
    logic [7:0]  push_addr;
    logic [7:0]  pop_addr;
    logic [3:0]  push_nib;

    // status word: levels+flags in high half, carry+skips low
    assign psw_cat  = {frame_in.psw_hi, frame_in.psw_lo};
    // call frame: flags nibble holds mem/reg bank enables only
    assign flag_cat = {2'b00, frame_in.psw_hi[1:0], 4'h0};
    // top nibble of a six-nibble frame is spare, stored as zero
    assign push_data =
        op_in == SPC_OP_INT  ? {4'h0, frame_in.pc, psw_cat} :
        op_in == SPC_OP_CALL ? {4'h0, frame_in.pc, flag_cat} :
                               {16'h0000, frame_in.pair};

    // push writes sp-1 downward, pop reads sp upward
    assign push_addr = stack_top_pointer_r - {5'h00, cnt_r}
                       - 8'h01;
    assign pop_addr  = stack_top_pointer_r + {5'h00, cnt_r};
    // highest nibble still unsent sits at the top of the frame
    assign push_nib  = shift_r[{total_r, 2'b00} - 5'd1 -: 4];

    ////////////////////////////////////////////////////////////////////////
    // pointer next value
    always_comb
    begin
        sp_nxt = stack_top_pointer_r;
        if (state_r == SPC_ST_PUSH && last)
            sp_nxt = stack_top_pointer_r - step_r;
        else if (state_r == SPC_ST_POP && last)
            sp_nxt = stack_top_pointer_r + step_r;
        else if (sp_wr_lo)
            sp_nxt = {stack_top_pointer_r[7:4],
                      reg_in.wdata[3:1], 1'b0};
        else if (sp_wr_hi)
            sp_nxt = {reg_in.wdata, stack_top_pointer_r[3:0]};
        sp_nxt[0] = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // pointer has no reset value; software initialises it
    always_ff @(posedge clk_in)
        stack_top_pointer_r <= sp_nxt;

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            state_r     <= SPC_ST_IDLE;
            op_r        <= SPC_OP_NONE;
            cnt_r       <= 3'h0;
            total_r     <= `SPC_NIB_PAIR;
            shift_r     <= 24'h000000;
            mem_r       <= '0;
            frame_r     <= '0;
            done_r      <= 1'b0;
            reg_rdata_r <= 4'h0;
            work_bank_r <= 2'h0;
            step_r      <= `SPC_STEP_PAIR;
            rd_pend_r   <= 1'b0;
            rd_last0_r  <= 1'b0;
            rd_last_r   <= 1'b0;
        end
        else
        begin
            done_r      <= 1'b0;
            mem_r       <= '0;
            rd_pend_r   <= rd_strobe;
            rd_last0_r  <= state_r == SPC_ST_POP && last;
            rd_last_r   <= rd_last0_r;
            // read value holds until the next access
            if (reg_in.en)
                reg_rdata_r <= hit_hi ? stack_top_pointer_r[7:4]
                                      : {stack_top_pointer_r[3:1],
                                         1'b0};
            // bank select only counts while its enable is set
            work_bank_r <= frame_r.psw_hi[0] ? reg_bank_select_in
                                             : 2'h0;
            case (state_r)
                SPC_ST_IDLE:
                begin
                    cnt_r   <= 3'h0;
                    total_r <= nib_total;
                    step_r  <= step;
                    // kept until the read tail of a pop has finished
                    if (is_push || is_pop)
                        op_r <= op_in;
                    if (is_push)
                    begin
                        shift_r <= push_data;
                        state_r <= SPC_ST_PUSH;
                    end
                    else if (is_pop)
                    begin
                        shift_r <= 24'h000000;
                        state_r <= SPC_ST_POP;
                    end
                    if (op_in == SPC_OP_INT)
                        frame_r.psw_hi <= frame_in.psw_hi;
                end
                SPC_ST_PUSH:
                begin
                    // high nibble of frame goes to highest address
                    mem_r.en    <= 1'b1;
                    mem_r.we    <= 1'b1;
                    mem_r.addr  <= {`SPC_STACK_BANK, push_addr};
                    mem_r.wdata <= push_nib;
                    shift_r     <= shift_r << 4;
                    cnt_r       <= cnt_r + 3'h1;
                    if (last)
                    begin
                        state_r <= SPC_ST_IDLE;
                        done_r  <= 1'b1;
                        // level flags step up once frame is saved
                        if (op_r == SPC_OP_INT)
                            frame_r.psw_hi[3:2] <=
                                frame_r.psw_hi[3:2] + 2'h1;
                    end
                end
                SPC_ST_POP:
                begin
                    // low nibble first; data lands next cycle
                    mem_r.en   <= 1'b1;
                    mem_r.addr <= {`SPC_STACK_BANK, pop_addr};
                    cnt_r      <= cnt_r + 3'h1;
                    if (last)
                        state_r <= SPC_ST_IDLE;
                end
                default:
                    state_r <= SPC_ST_IDLE;
            endcase
            // collect nibbles two edges behind the read strobe
            if (rd_pend_r)
            begin
                shift_r <= {mem_rdata_in, shift_r[23:4]};
                if (rd_last_r)
                begin
                    done_r <= 1'b1;
                    case (op_r)
                        SPC_OP_POP:
                            frame_r.pair <= {mem_rdata_in,
                                             shift_r[23:20]};
                        SPC_OP_RET:
                        begin
                            // spare top nibble is dropped
                            frame_r.pc <= shift_r[23:12];
                            frame_r.psw_hi[1:0] <= shift_r[9:8];
                        end
                        SPC_OP_INTERRUPT_EXIT_OP:
                        begin
                            frame_r.pc     <= shift_r[23:12];
                            frame_r.psw_hi <= shift_r[11:8];
                            frame_r.psw_lo <= shift_r[7:4];
                        end
                        default:
                            done_r <= 1'b1;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            busy_out <= 1'b0;
        else
            busy_out <= sp_busy_nxt;
    end

    assign reg_rdata_out         = reg_rdata_r;
    assign mem_out               = mem_r;
    assign frame_out             = frame_r;
    assign done_out              = done_r;
    assign stack_top_pointer_out = stack_top_pointer_r;
    assign work_bank_out         = work_bank_r;
endmodule
`default_nettype wire

// file: pkg/spc_params.svh
// constants for the stack pointer control block
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH
`define SPC_ADDR_SP_LO    12'hF80
`define SPC_ADDR_SP_HI    12'hF81
`define SPC_STEP_PAIR     8'h02
`define SPC_STEP_FRAME    8'h06
`define SPC_NIB_PAIR      3'h2
`define SPC_NIB_FRAME     3'h6
`define SPC_STACK_BANK    4'h0
`endif

// file: pkg/spc_pkg.sv
// types for the stack pointer control block
`default_nettype none
package spc_pkg;
    typedef enum logic [2:0] {
        SPC_OP_NONE,
        SPC_OP_PUSH,
        SPC_OP_POP,
        SPC_OP_CALL,
        SPC_OP_RET,
        SPC_OP_INT,
        SPC_OP_INTERRUPT_EXIT_OP
    } spc_op_e;

    typedef enum logic [1:0] {
        SPC_ST_IDLE,
        SPC_ST_PUSH,
        SPC_ST_POP
    } spc_state_e;

    // frame contents handed in on push and out on pop
    typedef struct packed {
        logic [11:0] pc;
        logic [3:0]  psw_hi;
        logic [3:0]  psw_lo;
        logic [7:0]  pair;
    } spc_frame_s;

    // data memory request toward the ram
    typedef struct packed {
        logic        en;
        logic        we;
        logic [11:0] addr;
        logic [3:0]  wdata;
    } spc_mem_s;

    // nibble register access from the cpu
    typedef struct packed {
        logic        en;
        logic        we;
        logic [11:0] addr;
        logic [3:0]  wdata;
    } spc_reg_s;
endpackage
`default_nettype wire

// file: tb/spc_ram_model.sv
// behavioural data memory facing the stack sequencer
`default_nettype none
module spc_ram_model
(
    input  wire logic              clk_in,
    input  wire spc_pkg::spc_mem_s mem_in,
    output logic [3:0]             rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import spc_pkg::*;
    logic [3:0] mem [0:255];
    // idle cycles flip the read data so a stale nibble never passes
    always_ff @(posedge clk_in)
    begin
        if (mem_in.en && mem_in.we)
            mem[mem_in.addr[7:0]] <= mem_in.wdata;
        if (mem_in.en && !mem_in.we)
            rdata_out <= mem[mem_in.addr[7:0]];
        else
            rdata_out <= ~rdata_out;
    end
endmodule
`default_nettype wire

// file: tb/spc_stack_ctrl_monitor.sv
// checker for the stack pointer control block
`default_nettype none
module spc_stack_ctrl_monitor
(
    input wire logic                clk_in,
    input wire logic                rstn_in,
    input wire spc_pkg::spc_op_e    op_in,
    input wire spc_pkg::spc_frame_s frame_in,
    input wire spc_pkg::spc_reg_s   reg_in,
    input wire logic [3:0]          mem_rdata_in,
    input wire logic [1:0]          reg_bank_select_in,
    input wire logic [3:0]          reg_rdata_out,
    input wire spc_pkg::spc_mem_s   mem_out,
    input wire spc_pkg::spc_frame_s frame_out,
    input wire logic                done_out,
    input wire logic                busy_out,
    input wire logic [7:0]          stack_top_pointer_out,
    input wire logic [1:0]          work_bank_out
);
    import spc_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    wire logic [7:0] sp_w;
    wire logic       go_w;
    wire logic       fpush_w;
    wire logic       fpop_w;
    assign sp_w = stack_top_pointer_out;
    assign go_w = !busy_out && op_in != SPC_OP_NONE;
    assign fpush_w = go_w && (op_in == SPC_OP_CALL || op_in == SPC_OP_INT);
    assign fpop_w = go_w && (op_in == SPC_OP_RET || op_in == SPC_OP_INTERRUPT_EXIT_OP);
    ////////////////////////////////////////////////////////////////////////
    a_mem_bank_zero: assert property (
        mem_out.en |-> mem_out.addr[11:8] == 4'h0)
        else $error("stack left bank 0");
    a_ptr_even: assert property (
        done_out |-> sp_w[0] == 1'b0)
        else $error("pointer odd");
    a_push_pair: assert property (
        go_w && op_in == SPC_OP_PUSH |->
        ##2 mem_out.en && mem_out.we && !done_out
        && mem_out.addr[7:0] == $past(sp_w, 2) - 8'h01
        ##1 mem_out.en && mem_out.we && done_out
        && mem_out.addr[7:0] == $past(sp_w, 3) - 8'h02)
        else $error("pair push order wrong");
    a_pair_step: assert property (
        go_w && op_in == SPC_OP_PUSH |-> ##3 sp_w == $past(sp_w, 3) - 8'h02)
        else $error("push step wrong");
    a_frame_push: assert property (
        fpush_w |-> ##2 (mem_out.en && mem_out.we && !done_out)[*5]
        ##1 mem_out.en && mem_out.we && done_out)
        else $error("frame push length");
    a_frame_step: assert property (
        fpush_w |-> ##7 sp_w == $past(sp_w, 7) - 8'h06)
        else $error("frame step wrong");
    a_pop_read: assert property (
        go_w && op_in == SPC_OP_POP |->
        ##2 mem_out.en && !mem_out.we
        && mem_out.addr[7:0] == $past(sp_w, 2)
        ##1 mem_out.en && !mem_out.we
        && mem_out.addr[7:0] == $past(sp_w, 3) + 8'h01
        ##2 done_out)
        else $error("pair pop order wrong");
    a_ret_step: assert property (
        fpop_w |-> ##9 done_out && sp_w == $past(sp_w, 9) + 8'h06)
        else $error("return step wrong");
    a_bank_gate: assert property (
        !frame_out.psw_hi[0] [*2] |-> work_bank_out == 2'h0)
        else $error("bank used while disabled");
endmodule
bind spc_stack_ctrl spc_stack_ctrl_monitor u_mon
(
    .clk_in(clk_in), .rstn_in(rstn_in), .op_in(op_in),
    .frame_in(frame_in), .reg_in(reg_in), .mem_rdata_in(mem_rdata_in),
    .reg_bank_select_in(reg_bank_select_in),
    .reg_rdata_out(reg_rdata_out), .mem_out(mem_out),
    .frame_out(frame_out), .done_out(done_out), .busy_out(busy_out),
    .stack_top_pointer_out(stack_top_pointer_out),
    .work_bank_out(work_bank_out)
);
`default_nettype wire

// file: tb/spc_stack_ctrl_test.sv
// self-checking bench for the stack pointer control block
`default_nettype none
module spc_stack_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    import spc_pkg::*;
    localparam spc_frame_s PAIR_F = '{12'h000, 4'h0, 4'h0, 8'h5A};
    localparam spc_frame_s CALL_F = '{12'h3C5, 4'h2, 4'h0, 8'h00};
    localparam spc_frame_s INT_F = '{12'h7E1, 4'h3, 4'h9, 8'h00};
    logic clk_in, rstn_in, done_out, busy_out;
    logic [3:0] mem_rdata, reg_rdata_out;
    logic [1:0] bank_sel, work_bank;
    logic [7:0] sp;
    spc_op_e op_in;
    spc_frame_s frame_in, frame_out;
    spc_reg_s reg_in;
    spc_mem_s mem_out;
    int err_count, num_checks;
    spc_stack_ctrl DUT (.clk_in(clk_in), .rstn_in(rstn_in), .op_in(op_in),
        .frame_in(frame_in), .reg_in(reg_in), .mem_rdata_in(mem_rdata),
        .reg_bank_select_in(bank_sel), .reg_rdata_out(reg_rdata_out),
        .mem_out(mem_out), .frame_out(frame_out), .done_out(done_out),
        .busy_out(busy_out), .stack_top_pointer_out(sp),
        .work_bank_out(work_bank));
    spc_ram_model u_ram (.clk_in(clk_in), .mem_in(mem_out),
        .rdata_out(mem_rdata));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [11:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic reg_wr(input logic [11:0] a, input logic [3:0] d);
        @(posedge clk_in) reg_in <= '{1'b1, 1'b1, a, d};
        @(posedge clk_in) reg_in.en <= 1'b0;
    endtask
    task automatic reg_rd(input logic [11:0] a, input logic [3:0] e);
        @(posedge clk_in) reg_in <= '{1'b1, 1'b0, a, 4'h0};
        @(posedge clk_in) reg_in.en <= 1'b0;
        @(posedge clk_in) chk("reg_rdata", {8'h0, e}, {8'h0, reg_rdata_out});
    endtask
    // frame stays held until done; the next op waits one idle edge
    task automatic do_op(input spc_op_e op, input spc_frame_s f,
                         input logic [7:0] sp_e);
        int i;
        @(posedge clk_in)
        begin
            op_in <= op;
            frame_in <= f;
        end
        @(posedge clk_in) op_in <= SPC_OP_NONE;
        i = 0;
        while (done_out !== 1'b1 && i < 20)
        begin
            @(posedge clk_in);
            i++;
        end
        chk("done", 12'h001, {11'h0, done_out});
        @(posedge clk_in);
        chk("pointer", {4'h0, sp_e}, {4'h0, sp});
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    initial
    begin
        #5000;
        err_count++;
        stop_test();
    end
    initial
    begin
        rstn_in = 1'b0;
        op_in = SPC_OP_NONE;
        frame_in = '0;
        reg_in = '0;
        bank_sel = 2'h3;
        err_count = 0;
        num_checks = 0;
        repeat (2) @(posedge clk_in);
        rstn_in <= 1'b1;
        reg_wr(12'hF80, 4'hF);
        reg_wr(12'hF81, 4'hA);
        reg_rd(12'hF80, 4'hE);
        reg_rd(12'hF81, 4'hA);
        reg_wr(12'hF80, 4'h0);
        reg_wr(12'hF81, 4'h0);
        do_op(SPC_OP_PUSH, PAIR_F, 8'hFE);
        chk("ram_ff", 12'h005, {8'h0, u_ram.mem[8'hFF]});
        chk("ram_fe", 12'h00A, {8'h0, u_ram.mem[8'hFE]});
        do_op(SPC_OP_CALL, CALL_F, 8'hF8);
        do_op(SPC_OP_INT, INT_F, 8'hF2);
        chk("levels", 12'h001, {10'h0, frame_out.psw_hi[3:2]});
        do_op(SPC_OP_INTERRUPT_EXIT_OP, '0, 8'hF8);
        chk("interrupt_exit_op_pc", 12'h7E1, frame_out.pc);
        chk("status", 12'h039, {frame_out.psw_hi, frame_out.psw_lo});
        repeat (2) @(posedge clk_in);
        chk("bank_on", 12'h003, {10'h0, work_bank});
        do_op(SPC_OP_RET, '0, 8'hFE);
        chk("ret_pc", 12'h3C5, frame_out.pc);
        chk("flags", 12'h002, {10'h0, frame_out.psw_hi[1:0]});
        repeat (2) @(posedge clk_in);
        chk("bank_off", 12'h000, {10'h0, work_bank});
        do_op(SPC_OP_POP, '0, 8'h00);
        chk("pair", 12'h05A, {4'h0, frame_out.pair});
        stop_test();
    end
endmodule
`default_nettype wire
